// ===== hw/tcu_capture_unit.sv
// Capture channel: timer, edge event selection, holding register, APB slave, interrupt
// Assumes: APB master on clk; all pins synchronous to clk; single clock domain
`timescale 1ns/1ps

module tcu_capture_unit #(
    parameter int TCY_DIV = 4
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        capture_pin_in,
    output logic             capture_pin_out,
    output logic             capture_pin_oe_n,
    input  wire logic        timer_ext_clk,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////////
    localparam int TW = tcu_pkg::TIMER_W;

    typedef struct packed {
        logic [3:0]    mode;
        logic [TW-1:0] hold;
        logic [7:0]    irq_flags;
        logic [7:0]    irq_en;
        logic [7:0]    portc_dir;
        logic [7:0]    portc_out;
        logic [2:0]    tctrl;
        logic [3:0]    presc;
        logic [1:0]    tcy_cnt;
        logic          tick;
        logic [31:0]   rdata;
        logic          ready;
        logic          slverr;
        logic          irq;
        logic          pin_out;
        logic          pin_oe_n;
    } tcu_state_type;

    tcu_state_type st_r;
    tcu_state_type st_nxt;

    logic          rise;
    logic          fall;
    logic [TW-1:0] timer_count;
    logic          pin_level;
    logic          timer_load;

    ////////////////////////////////////////////////////////////////////////////
    // Pin seen through the port: output latch when driving, outside level otherwise
    assign pin_level = st_r.portc_dir[tcu_pkg::CAPTURE_PIN_BIT] ? capture_pin_in
                                                                : st_r.portc_out[tcu_pkg::CAPTURE_PIN_BIT];

    tcu_edge_det u_edge (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (pin_level),
        .rise  (rise),
        .fall  (fall)
    );

    assign timer_load = psel && penable && pwrite && !st_r.ready && (paddr == tcu_pkg::ADDR_TIMER);

    tcu_timer #(
        .WIDTH (TW)
    ) u_timer (
        .clk        (clk),
        .rst_n      (rst_n),
        .run        (st_r.tctrl[tcu_pkg::TCTRL_ON_BIT]),
        .ext_src    (st_r.tctrl[tcu_pkg::TCTRL_SRC_BIT]),
        .tick_en    (st_r.tick),
        .ext_clk_in (timer_ext_clk),
        .load       (timer_load),
        .load_val   (pwdata[TW-1:0]),
        .count      (timer_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic       access;
        logic       event_hit;
        logic       mode_wr;
        logic [3:0] new_mode;
        access    = psel && penable && !st_r.ready;
        event_hit = 1'b0;
        mode_wr   = access && pwrite && (paddr == tcu_pkg::ADDR_MODE_CTRL);
        new_mode  = pwdata[3:0];
        st_nxt    = st_r;

        // Instruction-cycle enable from the divider
        st_nxt.tick = 1'b0;
        if (st_r.tcy_cnt == 2'(TCY_DIV - 1)) begin
            st_nxt.tcy_cnt = 2'h0;
            st_nxt.tick    = 1'b1;
        end else begin
            st_nxt.tcy_cnt = st_r.tcy_cnt + 2'h1;
        end

        // Event selection and prescaler
        if (!tcu_pkg::is_capture_mode(st_r.mode)) begin
            st_nxt.presc = '0;
        end else begin
            unique case (st_r.mode)
                tcu_pkg::MODE_CAP_FALL:  event_hit = fall;
                tcu_pkg::MODE_CAP_RISE:  event_hit = rise;
                tcu_pkg::MODE_CAP_RISE4: begin
                    if (rise) begin
                        event_hit    = (st_r.presc[1:0] == tcu_pkg::PRESC_LAST4[1:0]);
                        st_nxt.presc = st_r.presc + 4'h1;
                    end
                end
                tcu_pkg::MODE_CAP_RISE16: begin
                    if (rise) begin
                        event_hit    = (st_r.presc == tcu_pkg::PRESC_LAST16);
                        st_nxt.presc = st_r.presc + 4'h1;
                    end
                end
            endcase
        end

        // Capture overwrites whatever is held, read or not
        if (event_hit) begin
            st_nxt.hold = timer_count;
        end

        // APB access, answered one cycle after the access phase starts
        st_nxt.ready  = access;
        st_nxt.slverr = 1'b0;
        st_nxt.rdata  = '0;
        if (access) begin
            if (pwrite) begin
                unique case (paddr)
                    tcu_pkg::ADDR_MODE_CTRL: begin
                        st_nxt.mode = new_mode;
                        // Prescaler count survives a direct switch between capture modes
                        if (!tcu_pkg::is_capture_mode(new_mode)) begin
                            st_nxt.presc = '0;
                        end
                    end
                    tcu_pkg::ADDR_TIMER_CTRL:  st_nxt.tctrl = pwdata[2:0];
                    tcu_pkg::ADDR_IRQ_CLEAR:   st_nxt.irq_flags = st_r.irq_flags & ~pwdata[7:0];
                    tcu_pkg::ADDR_IRQ_ENABLES: st_nxt.irq_en = pwdata[7:0];
                    tcu_pkg::ADDR_PORTC_DIR:   st_nxt.portc_dir = pwdata[7:0];
                    tcu_pkg::ADDR_PORTC_OUT:   st_nxt.portc_out = pwdata[7:0];
                    tcu_pkg::ADDR_HOLD, tcu_pkg::ADDR_TIMER, tcu_pkg::ADDR_IRQ_FLAGS: ;
                    default:                   st_nxt.slverr = 1'b1;
                endcase
            end else begin
                unique case (paddr)
                    tcu_pkg::ADDR_MODE_CTRL:   st_nxt.rdata = {28'h0, st_r.mode};
                    tcu_pkg::ADDR_HOLD:        st_nxt.rdata = {16'h0, st_r.hold};
                    tcu_pkg::ADDR_TIMER:       st_nxt.rdata = {16'h0, timer_count};
                    tcu_pkg::ADDR_TIMER_CTRL:  st_nxt.rdata = {29'h0, st_r.tctrl};
                    tcu_pkg::ADDR_IRQ_FLAGS:   st_nxt.rdata = {24'h0, st_r.irq_flags};
                    tcu_pkg::ADDR_IRQ_ENABLES: st_nxt.rdata = {24'h0, st_r.irq_en};
                    tcu_pkg::ADDR_PORTC_DIR:   st_nxt.rdata = {24'h0, st_r.portc_dir};
                    tcu_pkg::ADDR_PORTC_OUT:   st_nxt.rdata = {24'h0, st_r.portc_out};
                    tcu_pkg::ADDR_IRQ_CLEAR:   st_nxt.rdata = '0;
                    default:                   st_nxt.slverr = 1'b1;
                endcase
            end
        end

        // Set after clear so a capture in the clearing cycle is kept.
        // A mode write that changes the mode to a different capture mode is treated as a
        // capture event for the flag only, which is the spurious interrupt software must mask.
        if (event_hit || (mode_wr && tcu_pkg::is_capture_mode(new_mode) && new_mode != st_r.mode)) begin
            st_nxt.irq_flags[tcu_pkg::CAPTURE_IRQ_BIT] = 1'b1;
        end

        st_nxt.irq      = |(st_nxt.irq_flags & st_nxt.irq_en);
        st_nxt.pin_out  = st_nxt.portc_out[tcu_pkg::CAPTURE_PIN_BIT];
        st_nxt.pin_oe_n = st_nxt.portc_dir[tcu_pkg::CAPTURE_PIN_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r           <= '0;
            st_r.mode      <= tcu_pkg::MODE_RESET;
            st_r.presc     <= '0;
            st_r.portc_dir <= tcu_pkg::PORTC_DIR_RESET;
            st_r.portc_out <= tcu_pkg::PORTC_OUT_RESET;
            st_r.tctrl     <= tcu_pkg::TCTRL_RESET;
            st_r.pin_oe_n  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata           = st_r.rdata;
    assign pready           = st_r.ready;
    assign pslverr          = st_r.slverr;
    assign irq              = st_r.irq;
    assign capture_pin_out  = st_r.pin_out;
    assign capture_pin_oe_n = st_r.pin_oe_n;

endmodule

// ===== hw/tcu_pkg.sv
// Package: register map, field layout and reset values of the capture unit
// Assumes: APB slave with 32-bit data, one aligned word per register
package tcu_pkg;

    localparam logic [11:0] ADDR_MODE_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_HOLD        = 12'h004;
    localparam logic [11:0] ADDR_TIMER       = 12'h008;
    localparam logic [11:0] ADDR_TIMER_CTRL  = 12'h00C;
    localparam logic [11:0] ADDR_IRQ_FLAGS   = 12'h010;
    localparam logic [11:0] ADDR_IRQ_CLEAR   = 12'h014;
    localparam logic [11:0] ADDR_IRQ_ENABLES = 12'h018;
    localparam logic [11:0] ADDR_PORTC_DIR   = 12'h01C;
    localparam logic [11:0] ADDR_PORTC_OUT   = 12'h020;

    localparam int CAPTURE_IRQ_BIT  = 2;
    localparam int CAPTURE_PIN_BIT  = 2;
    localparam int MODE_W           = 4;
    localparam int TIMER_W          = 16;

    localparam logic [3:0] MODE_OFF       = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;

    localparam int TCTRL_ON_BIT   = 0;
    localparam int TCTRL_SRC_BIT  = 1;
    localparam int TCTRL_ASYNC_BIT = 2;

    localparam logic [3:0] MODE_RESET       = 4'h0;
    localparam logic [7:0] PORTC_DIR_RESET  = 8'hFF;
    localparam logic [7:0] PORTC_OUT_RESET  = 8'h00;
    localparam logic [2:0] TCTRL_RESET      = 3'h0;

    localparam int PRESC_W = 4;
    localparam logic [3:0] PRESC_LAST4  = 4'h3;
    localparam logic [3:0] PRESC_LAST16 = 4'hF;

    function automatic logic is_capture_mode(input logic [3:0] m);
        return (m[3:2] == 2'b01);
    endfunction

endpackage

// ===== hw/tcu_edge_det.sv
// Edge detector for the capture pin
// Assumes: pin already synchronous to clk; clock and reset shared with the top
`timescale 1ns/1ps

module tcu_edge_det (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
    } tcu_edge_state_type;

    tcu_edge_state_type st_r;
    tcu_edge_state_type st_nxt;

    // Two stages before the edge compare; only the second stage is looked at
    always_comb begin
        st_nxt       = st_r;
        st_nxt.sync1 = pin;
        st_nxt.sync2 = st_r.sync1;
        st_nxt.last  = st_r.sync2;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise = st_r.sync2 & ~st_r.last;
    assign fall = ~st_r.sync2 & st_r.last;

endmodule

// ===== hw/tcu_timer.sv
// 16-bit timer count feeding the capture unit
// Assumes: ext_clk_in synchronous to clk; tick_en is the instruction-cycle enable
`timescale 1ns/1ps

module tcu_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic             ext_src,
    input  wire logic             tick_en,
    input  wire logic             ext_clk_in,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    output logic      [WIDTH-1:0] count
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             ext_last;
    } tcu_timer_state_type;

    tcu_timer_state_type st_r;
    tcu_timer_state_type st_nxt;

    always_comb begin
        st_nxt          = st_r;
        st_nxt.ext_last = ext_clk_in;
        if (load) begin
            st_nxt.cnt = load_val;
        end else if (run) begin
            if (ext_src ? (ext_clk_in & ~st_r.ext_last) : tick_en) begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign count = st_r.cnt;

endmodule

// ===== verif/tcu_pin_src.sv
// Pin source model: drives the capture pin and resolves it with the port output
// Assumes: bench clock; levels change just after a rising edge
`timescale 1ns/1ps
module tcu_pin_src (
    input  wire logic clk,
    input  wire logic pin_out,
    input  wire logic pin_oe_n,
    output logic      pin
);
    logic src_r = 1'b0;
    // Port output wins while driving, so latch writes also show on capture_pin_in as on a real pad
    assign pin = pin_oe_n ? src_r : pin_out;
    task automatic set_level(input logic l);
        @(posedge clk);
        src_r <= l;
        // Six cycles a level outlast the synchroniser and edge stage
        repeat (6) @(posedge clk);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            set_level(1'b1);
            set_level(1'b0);
        end
    endtask
endmodule

// ===== verif/tcu_capture_unit_sva.sv
// Checker: APB answer timing and capture interrupt behaviour at the ports
// Assumes: bound to tcu_capture_unit; one clock, async active-low reset
`timescale 1ns/1ps
module tcu_capture_unit_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        capture_pin_in,
    input wire logic        irq
);
    logic       take;
    logic [3:0] mode_r;
    logic       en_r;
    logic [3:0] quiet_r;
    assign take = psel && penable && pwrite && !pready;
    // Shadow of mode and enable, so antecedents know what software selected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r  <= 4'h0;
            en_r    <= 1'b0;
            quiet_r <= 4'h0;
        end else begin
            if (take && paddr == tcu_pkg::ADDR_MODE_CTRL) begin
                mode_r <= pwdata[3:0];
            end
            if (take && paddr == tcu_pkg::ADDR_IRQ_ENABLES) begin
                en_r <= pwdata[2];
            end
            quiet_r <= take ? 4'h0 : ((quiet_r == 4'hF) ? quiet_r : quiet_r + 4'h1);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_irq_soon;
        ##[1:6] irq;
    endsequence
    sequence s_rise;
        $rose(capture_pin_in) && en_r && mode_r == tcu_pkg::MODE_CAP_RISE;
    endsequence
    sequence s_fall;
        $fell(capture_pin_in) && en_r && mode_r == tcu_pkg::MODE_CAP_FALL;
    endsequence
    property p_ready_next; psel && penable && !pready |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_map; pslverr |-> pready && paddr > tcu_pkg::ADDR_PORTC_OUT; endproperty
    property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
    property p_irq_hold; $fell(irq) |-> quiet_r < 4'h3; endproperty
    property p_rise_cap; s_rise |-> s_irq_soon; endproperty
    property p_fall_cap; s_fall |-> s_irq_soon; endproperty
    property p_off_quiet; mode_r == tcu_pkg::MODE_OFF && quiet_r > 4'h6 |-> !$rose(irq); endproperty
    property p_irq_en; $rose(irq) |-> en_r || $past(en_r); endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready late");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
    a_err_map: assert property (p_err_map) else $error("pslverr on mapped address");
    a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
    a_rise_cap: assert property (p_rise_cap) else $error("rise missed");
    a_fall_cap: assert property (p_fall_cap) else $error("fall missed");
    a_off_quiet: assert property (p_off_quiet) else $error("irq while off");
    a_irq_en: assert property (p_irq_en) else $error("irq not enabled");
endmodule
bind tcu_capture_unit tcu_capture_unit_sva tcu_capture_unit_sva_inst (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin_in(capture_pin_in), .irq(irq)
);

// ===== verif/tb_top.sv
// Testbench: APB register tasks and capture scenarios
// Assumes: pin source model on the capture pin; bench drives the external timer clock
`timescale 1ns/1ps
module tb_top;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic        pin, pin_out, pin_oe_n, irq, ext_clk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int          errors, n_tests, k;
    logic [3:0]  pmode [2] = '{tcu_pkg::MODE_CAP_RISE4, tcu_pkg::MODE_CAP_RISE16};
    int          pcnt [2] = '{4, 16};
    tcu_capture_unit tcu_capture_unit_inst (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_pin_in(pin),
        .capture_pin_out(pin_out), .capture_pin_oe_n(pin_oe_n), .timer_ext_clk(ext_clk), .irq(irq));
    tcu_pin_src tcu_pin_src_inst (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin(pin));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask
    // Idle edge first, so a release and the next setup never share a time step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            chk("pready", 32'h1, 32'h0);
            stop_test();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic ck(input string n, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(n, x, q);
    endtask
    task automatic rst_seq();
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    task automatic setmode(input logic [3:0] m);
        wr(tcu_pkg::ADDR_IRQ_ENABLES, 32'h0);
        wr(tcu_pkg::ADDR_MODE_CTRL, 32'h0);
        wr(tcu_pkg::ADDR_MODE_CTRL, {28'h0, m});
        wr(tcu_pkg::ADDR_IRQ_CLEAR, 32'h4);
        wr(tcu_pkg::ADDR_IRQ_ENABLES, 32'h4);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        errors  = 0;
        n_tests = 0;
        {psel, penable, pwrite, paddr, pwdata, ext_clk} = '0;
        rst_seq();
        chk("oe_n", 32'h1, {31'h0, pin_oe_n});
        ck("mode", tcu_pkg::ADDR_MODE_CTRL, 32'h0);
        ck("dir", tcu_pkg::ADDR_PORTC_DIR, 32'hFF);
        ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk("pslverr", 32'h1, {31'h0, e});
        wr(tcu_pkg::ADDR_TIMER_CTRL, 32'h0);
        wr(tcu_pkg::ADDR_TIMER, 32'h1234);
        setmode(tcu_pkg::MODE_CAP_RISE);
        tcu_pin_src_inst.pulse(1);
        ck("hold", tcu_pkg::ADDR_HOLD, 32'h1234);
        ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h4);
        wr(tcu_pkg::ADDR_TIMER, 32'hBEEF);
        tcu_pin_src_inst.pulse(1);
        repeat (50) @(posedge clk);
        ck("hold", tcu_pkg::ADDR_HOLD, 32'hBEEF);
        ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h4);
        wr(tcu_pkg::ADDR_IRQ_CLEAR, 32'h4);
        ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h0);
        @(negedge clk);
        chk("irq", 32'h0, {31'h0, irq});
        setmode(tcu_pkg::MODE_CAP_FALL);
        wr(tcu_pkg::ADDR_TIMER, 32'h0A5A);
        tcu_pin_src_inst.set_level(1'b1);
        ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h0);
        wr(tcu_pkg::ADDR_TIMER, 32'h5A5A);
        tcu_pin_src_inst.set_level(1'b0);
        ck("hold", tcu_pkg::ADDR_HOLD, 32'h5A5A);
        setmode(tcu_pkg::MODE_CAP_RISE4);
        tcu_pin_src_inst.pulse(2);
        rst_seq();
        setmode(tcu_pkg::MODE_CAP_RISE4);
        tcu_pin_src_inst.pulse(2);
        ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h0);
        // Two pulses are left over, so a kept count would capture early
        for (k = 0; k < 2; k++) begin
            setmode(pmode[k]);
            tcu_pin_src_inst.pulse(pcnt[k] - 1);
            ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h0);
            tcu_pin_src_inst.pulse(1);
            ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h4);
        end
        setmode(tcu_pkg::MODE_CAP_RISE4);
        tcu_pin_src_inst.pulse(2);
        wr(tcu_pkg::ADDR_MODE_CTRL, {28'h0, tcu_pkg::MODE_CAP_RISE16});
        ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h4);
        wr(tcu_pkg::ADDR_IRQ_CLEAR, 32'h4);
        tcu_pin_src_inst.pulse(13);
        ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h0);
        tcu_pin_src_inst.pulse(1);
        ck("flags", tcu_pkg::ADDR_IRQ_FLAGS, 32'h4);
        setmode(tcu_pkg::MODE_CAP_RISE);
        wr(tcu_pkg::ADDR_TIMER, 32'h0F0F);
        wr(tcu_pkg::ADDR_PORTC_DIR, 32'hFB);
        repeat (2) @(negedge clk);
        chk("oe_n", 32'h0, {31'h0, pin_oe_n});
        wr(tcu_pkg::ADDR_PORTC_OUT, 32'h4);
        ck("hold", tcu_pkg::ADDR_HOLD, 32'h0F0F);
        wr(tcu_pkg::ADDR_PORTC_DIR, 32'hFF);
        wr(tcu_pkg::ADDR_TIMER, 32'h0);
        wr(tcu_pkg::ADDR_TIMER_CTRL, 32'h1);
        repeat (40) @(posedge clk);
        wr(tcu_pkg::ADDR_TIMER_CTRL, 32'h0);
        apb(1'b0, tcu_pkg::ADDR_TIMER, 32'h0);
        chk("timer", 32'hB, q);
        wr(tcu_pkg::ADDR_TIMER, 32'h0);
        wr(tcu_pkg::ADDR_TIMER_CTRL, 32'h3);
        // Counter mode: one count per sampled rising edge of the external clock
        repeat (5) begin
            ext_clk <= 1'b1;
            repeat (2) @(posedge clk);
            ext_clk <= 1'b0;
            repeat (2) @(posedge clk);
        end
        wr(tcu_pkg::ADDR_TIMER_CTRL, 32'h0);
        apb(1'b0, tcu_pkg::ADDR_TIMER, 32'h0);
        chk("timer_ext", 32'h5, q);
        stop_test();
    end
endmodule
